/* rtl/seemp_pkg.sv */
// What this block does
// - Two-pin select 01 puts clock on pin four, data on pin five.
// - At the end of every two-pin operation busy clears and interrupt pulses.
// - Receive shifts one byte in; it is in the data register when done.
// - Two-pin clock runs at 78 kHz during transfers, high after a no-op, START or STOP.
// - Illegal command codes do nothing and set control bit 7.
// - Control bit 6 is busy: one during an operation, reset zero.
// - Control bit 5 reads zero when the EEPROM acknowledged; resets one.
// - Control bit 4 reads zero when this block sent an acknowledge on a receive.
// - Codes 0000, 1001 and 0101 stop the clock; after a byte transfer it keeps toggling.
// - Code 0010 receives and acknowledges; 0110 receives last byte, no acknowledge.
// - Code 1001 makes a START, code 0101 makes a STOP.
// - Select 10 runs a 500 kHz three-wire port on the same lines.
// - In three-wire mode each control write moves up to eight bits.
// - Wait-for-ready holds busy until a rising edge on the data line.
// - Wait-for-ready is ignored when float-data is clear.
// - Float-data releases the data line right after the last rising edge.
// - Clock count 0..8 sets clocks issued; zero only applies float-data and wait-for-ready.
// - Reads shift in MSB first right-justified; writes shift out from bit 7.
package seemp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ = 25_000_000;
	localparam int unsigned TWO_PIN_SCL_HZ = 78_000;
	localparam int unsigned UWIRE_SCK_HZ = 500_000;
	// Quarter bit for the two-pin engine, half bit for three-wire
	localparam int unsigned TWO_PIN_QTR_CYC = SYS_CLK_HZ / (4 * TWO_PIN_SCL_HZ);
	localparam int unsigned UWIRE_HALF_CYC = SYS_CLK_HZ / (2 * UWIRE_SCK_HZ);
	localparam logic [7:0] TWO_PIN_DIV_LAST = 8'(TWO_PIN_QTR_CYC - 1);
	localparam logic [7:0] UWIRE_DIV_LAST = 8'(UWIRE_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// Interface select and commands
	// ----------------------------------------------------------------
	localparam logic [1:0] IFSEL_TWO_PIN = 2'h1;
	localparam logic [1:0] IFSEL_UWIRE = 2'h2;
	localparam logic [3:0] CMD_NOOP = 4'h0;
	localparam logic [3:0] CMD_RX_ACK = 4'h2;
	localparam logic [3:0] CMD_TX = 4'h3;
	localparam logic [3:0] CMD_STOP = 4'h5;
	localparam logic [3:0] CMD_RX_LAST = 4'h6;
	localparam logic [3:0] CMD_START = 4'h9;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_ERR_BIT = 7;
	localparam int unsigned CTRL_BUSY_BIT = 6;
	localparam int unsigned CTRL_RXACK_BIT = 5;
	localparam int unsigned CTRL_TXACK_BIT = 4;
	localparam int unsigned CTRL_WFR_BIT = 7;
	localparam int unsigned CTRL_HIZ_BIT = 5;
	localparam int unsigned CTRL_RD_BIT = 4;
	localparam logic [3:0] UW_CNT_MAX = 4'h8;
	localparam logic [3:0] ACK_BIT_IDX = 4'h8;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic ACK_N_RESET = 1'b1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_STOP,
		ST_TX,
		ST_RX,
		ST_UW_SHIFT,
		ST_UW_WAIT
	} seemp_state_e;

	// Processor write strobes with their data
	typedef struct packed {
		logic ctrl_we;
		logic data_we;
		logic [7:0] wdata;
	} seemp_sfr_wr_s;

	// Pin four carries the clock, pin five the data
	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
	} seemp_pins_s;

endpackage

/* rtl/seemp_sync.sv */
// Two-stage synchroniser for a pin level
module seemp_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Level in and out
	input wire logic async_in,
	output logic sync_out
);

	logic meta_reg;

	// First stage feeds only the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

/* rtl/seemp_top.sv */
// Serial EEPROM master: two-pin byte engine and three-wire bit shifter
module seemp_top
	import seemp_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Processor register access
	input wire seemp_sfr_wr_s sfr_wr,
	output logic [7:0] eeprom_control_rd,
	output logic [7:0] eeprom_data_reg,
	// Pin function select
	input wire logic [1:0] eeprom_if_select,
	// Serial pins
	input wire logic gpio_pin_five_in,
	output seemp_pins_s pins_out,
	// Completion event
	output logic eeprom_done_irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	seemp_state_e state_reg;
	seemp_state_e state_next;
	logic [7:0] div_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic [3:0] nbits_reg;
	logic [7:0] ctrl_rd_reg;
	logic err_reg;
	logic rx_ack_n_reg;
	logic tx_ack_n_reg;
	logic last_reg;
	logic free_run_reg;
	logic uw_rd_reg;
	logic uw_hiz_reg;
	logic uw_wfr_reg;
	logic uw_float_reg;
	logic sd_prev_reg;
	logic irq_reg;
	seemp_pins_s pins_reg;
	seemp_pins_s pins_next;
	logic sd_sync;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic cmd_legal(input logic [3:0] c);
		return (c == CMD_NOOP) || (c == CMD_RX_ACK) || (c == CMD_TX) ||
			(c == CMD_STOP) || (c == CMD_RX_LAST) || (c == CMD_START);
	endfunction

	function automatic logic [3:0] clamp_cnt(input logic [3:0] c);
		return (c > UW_CNT_MAX) ? UW_CNT_MAX : c;
	endfunction

	// Data line synchroniser
	seemp_sync u_sd_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(gpio_pin_five_in),
		.sync_out(sd_sync)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Mode select, command accept and bit timing
	wire mode_two = (eeprom_if_select == IFSEL_TWO_PIN);
	wire mode_uw = (eeprom_if_select == IFSEL_UWIRE);
	wire busy = (state_reg != ST_IDLE);
	wire wr_ok = sfr_wr.ctrl_we && !busy;
	wire two_acc = wr_ok && mode_two;
	wire uw_acc = wr_ok && mode_uw;
	wire [3:0] cmd = sfr_wr.wdata[3:0];
	wire legal = cmd_legal(cmd);
	wire [7:0] div_last = mode_uw ? UWIRE_DIV_LAST : TWO_PIN_DIV_LAST;
	wire tick = (div_reg == div_last);
	wire phase_last = mode_uw ? (phase_reg == 2'h1) : (phase_reg == 2'h3);
	wire sample = tick && (mode_uw ? (phase_reg == 2'h1) : (phase_reg == 2'h2));
	wire bit_end = tick && phase_last;
	wire uw_last_bit = (bit_reg == nbits_reg - 4'h1);
	wire uw_empty = (nbits_reg == 4'h0);
	wire sd_rise = sd_sync && !sd_prev_reg;
	wire byte_op = (state_reg == ST_TX) || (state_reg == ST_RX);
	wire byte_done = byte_op && bit_end && (bit_reg == ACK_BIT_IDX);
	wire shift_in = sample && ((byte_op && bit_reg != ACK_BIT_IDX) ||
		(state_reg == ST_UW_SHIFT && !uw_empty));
	wire uw_done = (state_reg == ST_UW_SHIFT) &&
		(uw_empty || (bit_end && uw_last_bit));

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Next state from accepted command or end of frame
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (two_acc && cmd == CMD_START) begin
					state_next = ST_START;
				end else if (two_acc && cmd == CMD_STOP) begin
					state_next = ST_STOP;
				end else if (two_acc && cmd == CMD_TX) begin
					state_next = ST_TX;
				end else if (two_acc &&
					(cmd == CMD_RX_ACK || cmd == CMD_RX_LAST)) begin
					state_next = ST_RX;
				end else if (uw_acc) begin
					state_next = ST_UW_SHIFT;
				end
			end
			ST_START, ST_STOP: begin
				if (bit_end) begin
					state_next = ST_IDLE;
				end
			end
			ST_TX, ST_RX: begin
				if (byte_done) begin
					state_next = ST_IDLE;
				end
			end
			ST_UW_SHIFT: begin
				if (uw_done) begin
					// Wait only counts when the line is released
					state_next = (uw_wfr_reg && uw_hiz_reg) ?
						ST_UW_WAIT : ST_IDLE;
				end
			end
			ST_UW_WAIT: begin
				if (sd_rise) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	// State and bit timing; divider free-runs so idle clock can toggle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			div_reg <= 8'h00;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			if (wr_ok) begin
				div_reg <= 8'h00;
				phase_reg <= 2'h0;
				bit_reg <= 4'h0;
			end else if (tick) begin
				div_reg <= 8'h00;
				phase_reg <= mode_uw ? {1'b0, ~phase_reg[0]} :
					phase_reg + 2'h1;
				if (phase_last && busy) begin
					bit_reg <= bit_reg + 4'h1;
				end
			end else begin
				div_reg <= div_reg + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Command latches and flags
	// ----------------------------------------------------------------
	// Fields kept for the duration of a command
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_reg <= 1'b0;
			nbits_reg <= 4'h0;
			uw_rd_reg <= 1'b0;
			uw_hiz_reg <= 1'b0;
			uw_wfr_reg <= 1'b0;
			uw_float_reg <= 1'b0;
		end else if (two_acc) begin
			last_reg <= (cmd == CMD_RX_LAST);
		end else if (uw_acc) begin
			nbits_reg <= clamp_cnt(cmd);
			uw_rd_reg <= sfr_wr.wdata[CTRL_RD_BIT];
			uw_hiz_reg <= sfr_wr.wdata[CTRL_HIZ_BIT];
			uw_wfr_reg <= sfr_wr.wdata[CTRL_WFR_BIT];
			uw_float_reg <= sfr_wr.wdata[CTRL_HIZ_BIT];
		end
	end

	// Error, acknowledge and idle-clock flags
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_reg <= 1'b0;
			rx_ack_n_reg <= ACK_N_RESET;
			tx_ack_n_reg <= ACK_N_RESET;
			free_run_reg <= 1'b0;
		end else begin
			if (two_acc) begin
				err_reg <= !legal;
			end
			if (state_reg == ST_TX && sample && bit_reg == ACK_BIT_IDX) begin
				rx_ack_n_reg <= sd_sync;
			end
			if (state_reg == ST_RX && bit_end && bit_reg == ACK_BIT_IDX) begin
				tx_ack_n_reg <= last_reg;
			end
			if (two_acc && (cmd == CMD_NOOP || cmd == CMD_START ||
				cmd == CMD_STOP)) begin
				free_run_reg <= 1'b0;
			end else if (byte_done) begin
				free_run_reg <= 1'b1;
			end
		end
	end

	// Data register: loaded by the processor, shifted by the engines
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			eeprom_data_reg <= DATA_RESET;
		end else if (sfr_wr.data_we && !busy) begin
			eeprom_data_reg <= sfr_wr.wdata;
		end else if (shift_in) begin
			// MSB first; reads end right-justified
			eeprom_data_reg <= {eeprom_data_reg[6:0], sd_sync};
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Byte data only moves in the low phase; START and STOP move it under a high clock
	always_comb begin
		pins_next = pins_reg;
		if (mode_two) begin
			pins_next.scl_oe = 1'b1;
			pins_next.sda_out = 1'b0;
			unique case (state_reg)
				ST_START: begin
					pins_next.scl_out = (phase_reg != 2'h3);
					pins_next.sda_oe = phase_reg[1];
				end
				ST_STOP: begin
					pins_next.scl_out = (phase_reg != 2'h0);
					pins_next.sda_oe = (phase_reg != 2'h3);
				end
				ST_TX: begin
					pins_next.scl_out = phase_reg[1];
					if (phase_reg == 2'h0) begin
						pins_next.sda_oe = (bit_reg == ACK_BIT_IDX) ? 1'b0 :
							!eeprom_data_reg[7];
					end
				end
				ST_RX: begin
					pins_next.scl_out = phase_reg[1];
					if (phase_reg == 2'h0) begin
						pins_next.sda_oe = (bit_reg == ACK_BIT_IDX) &&
							!last_reg;
					end
				end
				ST_IDLE, ST_UW_SHIFT, ST_UW_WAIT: begin
					pins_next.scl_out = free_run_reg ? phase_reg[1] :
						1'b1;
				end
			endcase
		end else if (mode_uw) begin
			pins_next.scl_oe = 1'b1;
			pins_next.scl_out = 1'b0;
			pins_next.sda_oe = !uw_float_reg;
			if (state_reg == ST_UW_SHIFT && !uw_empty) begin
				pins_next.scl_out = phase_reg[0];
				pins_next.sda_oe = !uw_rd_reg;
				if (!uw_rd_reg && phase_reg == 2'h0) begin
					pins_next.sda_out = eeprom_data_reg[7];
				end
				// Let go a cycle after the clock rises: bit held over edge
				if (uw_hiz_reg && uw_last_bit && phase_reg == 2'h1 &&
					pins_reg.scl_out) begin
					pins_next.sda_oe = 1'b0;
				end
			end
		end else begin
			// Pins belong to general I/O in other modes
			pins_next = '0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Read view, completion pulse and pins, all registered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_rd_reg <= {1'b0, 1'b0, ACK_N_RESET, ACK_N_RESET, 4'h0};
			irq_reg <= 1'b0;
			pins_reg <= '0;
			sd_prev_reg <= 1'b1;
		end else begin
			ctrl_rd_reg <= {err_reg, busy, rx_ack_n_reg, tx_ack_n_reg, 4'h0};
			irq_reg <= ctrl_rd_reg[CTRL_BUSY_BIT] && !busy;
			pins_reg <= pins_next;
			sd_prev_reg <= sd_sync;
		end
	end

	assign eeprom_control_rd = ctrl_rd_reg;
	assign eeprom_done_irq = irq_reg;
	assign pins_out = pins_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence tx_accept_s;
		two_acc && cmd == CMD_TX;
	endsequence

	sequence busy_seen_s;
		busy ##1 eeprom_control_rd[CTRL_BUSY_BIT];
	endsequence

	done_irq_a: assert property ($fell(eeprom_control_rd[CTRL_BUSY_BIT]) |->
		eeprom_done_irq) else $error("busy fell without interrupt");

	rx_shift_a: assert property (state_reg == ST_RX && shift_in |=>
		eeprom_data_reg[0] == $past(sd_sync)) else $error("bit lost");

	idle_high_a: assert property ((mode_two && !busy && !free_run_reg &&
		!wr_ok)[*2] |-> pins_out.scl_out) else $error("idle clock low");

	bad_cmd_a: assert property (two_acc && !legal |=> err_reg && !busy
		##1 eeprom_control_rd[CTRL_ERR_BIT]) else $error("no error flag");

	busy_flag_a: assert property (tx_accept_s |=> busy_seen_s)
		else $error("busy not shown");

	rx_ack_a: assert property (state_reg == ST_TX && sample &&
		bit_reg == ACK_BIT_IDX |=> rx_ack_n_reg == $past(sd_sync))
		else $error("ack not captured");

	tx_ack_a: assert property (state_reg == ST_RX && byte_done |=>
		tx_ack_n_reg == $past(last_reg)) else $error("ack flag wrong");

	noop_stop_a: assert property (two_acc && cmd == CMD_NOOP |=>
		!free_run_reg && !busy) else $error("noop left clock running");

	start_cond_a: assert property (state_reg == ST_START &&
		phase_reg == 2'h2 |=> pins_out.scl_out && pins_out.sda_oe)
		else $error("start malformed");

	uw_float_a: assert property (state_reg == ST_UW_SHIFT && uw_hiz_reg
		&& !uw_empty && uw_last_bit && phase_reg == 2'h1 &&
		pins_out.scl_out |=> !pins_out.sda_oe)
		else $error("data not released");

	wfr_hold_a: assert property (state_reg == ST_UW_WAIT && !sd_rise |=>
		state_reg == ST_UW_WAIT) else $error("wait ended early");

	wfr_ignore_a: assert property (state_reg == ST_UW_WAIT |->
		uw_hiz_reg) else $error("wait without float");

	zero_cnt_a: assert property (uw_acc && cmd == 4'h0 |=>
		state_reg == ST_UW_SHIFT ##1 state_reg != ST_UW_SHIFT)
		else $error("zero count clocked");

	busy_ignore_a: assert property (sfr_wr.ctrl_we && busy |=>
		$stable(nbits_reg) && $stable(last_reg)) else $error("write taken");

	other_mode_a: assert property (!mode_two && !mode_uw |=>
		!pins_out.scl_oe && !pins_out.sda_oe) else $error("pins driven");

endmodule

/* test/seemp_eeprom_model.sv */
// Serial EEPROM on the far side of the pins
module seemp_eeprom_model (
	// Clock and bus state
	input wire logic sys_clk,
	input wire logic [1:0] mode,
	input wire logic cs,
	input wire logic dev_oe,
	// Serial lines as resolved on the board
	input wire logic scl,
	input wire logic sda,
	// Data line drive
	output logic m_oe,
	output logic m_val
);
	timeunit 1ns;
	timeprecision 1ps;

	int pos = 0;
	int drv_pos = -1;
	int nbits = 0;
	logic send = 0;
	logic rose = 0;
	logic acked = 0;
	logic rdy_oe = 0;
	logic rdy_val = 0;
	logic [7:0] sh = 8'h00;
	logic [7:0] rx_byte = 8'h00;

	// Load a value to return, or get ready to take one
	task automatic arm(input logic snd, input logic [7:0] b, input int n);
		send = snd;
		sh = b << (8 - n); // Right-justified value leaves MSB first
		nbits = n;
		pos = 0;
		rose = 0;
		rdy_oe = 0;
		drv_pos = (mode == 2'h2) ? 0 : -1;
	endtask

	// Busy low as soon as the master lets go, then ready high
	task automatic ready_after(input int n);
		wait (!dev_oe);
		@(negedge sys_clk);
		rdy_val = 0;
		rdy_oe = 1;
		repeat (n) @(negedge sys_clk);
		rdy_val = 1;
	endtask

	// Take data and the acknowledge on the rising clock
	always @(posedge scl) begin
		if (pos < 8)
			rx_byte = {rx_byte[6:0], sda};
		if (pos == 8)
			acked = !sda;
		pos++;
		rose = 1;
	end

	// Change data only with the clock low, so no false start or stop
	always @(negedge scl) begin
		if (rose)
			sh = sh << 1;
		rose = 0;
		drv_pos = pos;
	end

	// Pull-down only in two-pin mode; three-wire drives while selected
	assign m_oe = (mode == 2'h1) ?
		(send ? (drv_pos >= 0 && drv_pos < 8 && !sh[7]) : drv_pos == 8) :
		(mode == 2'h2 && cs && (rdy_oe || (send && drv_pos < nbits)));
	assign m_val = rdy_oe ? rdy_val : sh[7];
endmodule

/* test/serial_eeprom_master_port_bench.sv */
// Self-checking bench for the serial EEPROM master
module serial_eeprom_master_port_bench
	import seemp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk = 0;
	logic rst_n = 0;
	seemp_sfr_wr_s sfr_wr = '0;
	logic [1:0] if_sel = IFSEL_TWO_PIN;
	logic cs = 0;
	logic float_val = 0;
	logic [7:0] ctrl_rd;
	logic [7:0] data_reg;
	logic irq;
	seemp_pins_s pins;
	logic scl_line;
	logic sda_line;
	logic m_oe;
	logic m_val;
	logic scl_q = 0;
	logic sda_q = 1;
	logic [15:0] rnd = 16'd25251;
	logic [3:0] rx_cmds [2] = '{CMD_RX_ACK, CMD_RX_LAST};
	int err_count = 0;
	int comparisons = 0;
	int scl_age = 0;
	int scl_per = 0;
	int rises = 0;
	int starts = 0;
	int stops = 0;

	// 25 MHz system clock
	always #20 sys_clk = ~sys_clk;

	seemp_top uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .sfr_wr(sfr_wr),
		.eeprom_control_rd(ctrl_rd), .eeprom_data_reg(data_reg),
		.eeprom_if_select(if_sel), .gpio_pin_five_in(sda_line),
		.pins_out(pins), .eeprom_done_irq(irq)
	);

	seemp_eeprom_model model (
		.sys_clk(sys_clk), .mode(if_sel), .cs(cs), .dev_oe(pins.sda_oe),
		.scl(scl_line), .sda(sda_line), .m_oe(m_oe), .m_val(m_val)
	);

	// Pull-up in two-pin mode; an undriven three-wire line wanders
	assign scl_line = pins.scl_oe ? pins.scl_out : (if_sel == IFSEL_TWO_PIN);
	assign sda_line = (if_sel == IFSEL_TWO_PIN) ?
		!((pins.sda_oe && !pins.sda_out) || m_oe) :
		(pins.sda_oe ? pins.sda_out : (m_oe ? m_val : float_val));

	// Line watcher: clock period, rises, start and stop marks
	always @(posedge sys_clk) begin
		float_val <= ~float_val;
		scl_age++;
		if (scl_line && !scl_q) begin
			scl_per = scl_age;
			scl_age = 0;
			rises++;
		end
		if (if_sel == IFSEL_TWO_PIN && scl_line && scl_q) begin
			starts += int'(sda_q && !sda_line);
			stops += int'(!sda_q && sda_line);
		end
		scl_q = scl_line;
		sda_q = sda_line;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd_byte();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd[7:0];
	endfunction

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle strobe, driven on the falling edge
	task automatic wr(input logic ctrl, input logic [7:0] v);
		@(negedge sys_clk);
		sfr_wr = {ctrl, !ctrl, v};
		@(negedge sys_clk);
		sfr_wr = '0;
	endtask

	// Bounded wait for busy to rise and fall again
	task automatic wait_done(output int cyc);
		logic seen;
		seen = 0;
		cyc = 0;
		while (cyc < 20000) begin
			@(negedge sys_clk);
			cyc++;
			if (ctrl_rd[6] === 1'b1)
				seen = 1;
			else if (seen)
				break;
		end
		check("irq", irq, 1);
	endtask

	// No-op, then the clock must stand high
	task automatic idle();
		int r;
		wr(1, {4'h0, CMD_NOOP});
		repeat (700) @(negedge sys_clk);
		r = rises;
		repeat (1000) @(negedge sys_clk);
		check("idle rises", rises - r, 0);
		check("idle clk", scl_line, 1);
	endtask

	// Drop select, then a zero-length write takes the line back
	task automatic drive_again();
		int r;
		int cyc;
		@(negedge sys_clk);
		cs = 0;
		r = rises;
		wr(1, 8'h00);
		wait_done(cyc);
		check("drive", pins.sda_oe, 1);
		check("no clocks", rises - r, 0);
		cs = 1;
	endtask

	task automatic test_done();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] b;
		int cyc;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1;
		check("ctrl", ctrl_rd, 8'h30);
		check("data", data_reg, 8'h00);
		@(negedge sys_clk);
		check("clk pin", {pins.scl_oe, scl_line}, 2'h3);
		wr(1, {4'h0, CMD_START});
		wait_done(cyc);
		check("starts", starts, 1);
		b = rnd_byte();
		wr(0, b);
		model.arm(0, b, 8);
		wr(1, {4'h0, CMD_TX});
		wr(1, 8'h0f);
		wait_done(cyc);
		check("sent", model.rx_byte, b);
		check("status", ctrl_rd[7:5], 3'h0);
		check("bit period", scl_per, 320);
		idle();
		foreach (rx_cmds[i]) begin
			b = rnd_byte();
			model.arm(1, b, 8);
			wr(1, {4'h0, rx_cmds[i]});
			wait_done(cyc);
			check("rx", data_reg, b);
			check("tx ack", ctrl_rd[4], i);
			check("ack seen", model.acked, !i);
			idle();
		end
		for (int c = 1; c < 16; c++) begin
			if (c inside {2, 3, 5, 6, 9})
				continue;
			wr(1, 8'(c));
			repeat (3) @(negedge sys_clk);
			check("err busy", ctrl_rd[7:6], 2'h2);
			wr(1, 8'h00);
			repeat (3) @(negedge sys_clk);
			check("err clr", ctrl_rd[7], 0);
		end
		wr(1, {4'h0, CMD_STOP});
		wait_done(cyc);
		check("stops", stops, 1);
		@(negedge sys_clk);
		if_sel = IFSEL_UWIRE; // Three-wire clock is the bench clock divided by 50
		cs = 1;
		b = rnd_byte();
		wr(0, b);
		model.arm(0, b, 8);
		wr(1, 8'h08);
		wait_done(cyc);
		check("uw sent", model.rx_byte, b);
		check("uw period", scl_per, 50);
		for (int n = 5; n < 9; n += 3) begin
			b = rnd_byte();
			model.arm(1, b, n);
			wr(1, 8'h10 | 8'(n));
			wait_done(cyc);
			check("uw read", data_reg & (8'hff >> (8 - n)),
				b & (8'hff >> (8 - n)));
			drive_again();
		end
		b = rnd_byte();
		wr(0, b);
		model.arm(0, b, 8);
		wr(1, 8'h28);
		wait_done(cyc);
		check("float", pins.sda_oe, 0);
		check("float sent", model.rx_byte, b);
		drive_again();
		model.arm(0, b, 8);
		fork
			model.ready_after(300);
		join_none
		wr(1, 8'ha8);
		wait_done(cyc);
		check("ready wait", cyc >= 650, 1);
		drive_again();
		wr(1, 8'h88);
		wait_done(cyc);
		check("no wait", cyc < 500, 1);
		// Pins go back to general I/O and commands are dropped
		@(negedge sys_clk);
		if_sel = 2'h0;
		wr(1, {4'h0, CMD_START});
		repeat (3) @(negedge sys_clk);
		check("pins off", {pins.scl_oe, pins.sda_oe, ctrl_rd[6]},
			3'h0);
		test_done();
	end

	// Hang guard, well above the expected run length
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_count++;
		test_done();
	end
endmodule
